// *** rtl/padc_top.sv ***
`timescale 1ns/1ps
`include "padc_params.svh"

module padc_top
    import padc_pkg::*;
(
    input wire logic CORE_CLK_IN,
    input wire logic RSTN_IN,
    input wire logic CONV_CLK_IN,
    input wire logic [17:0] STAGE_CODE_IN,
    input wire logic OUTPUT_HIZ_IN,
    input wire logic POWER_DOWN_IN,
    output logic [9:0] SAMPLE_OUT,
    output logic SAMPLE_OE_N_OUT,
    output logic SAMPLE_VALID_OUT,
    output logic TRACK_PHASE_OUT,
    output logic HOLD_PHASE_OUT
);

    // ---------------------------------------------
    // Declarations
    // ---------------------------------------------

    // Raw pins gathered for one synchroniser loop
    logic [`PADC_PINS-1:0] pin_raw;

    // Filtered pin levels
    logic [`PADC_PINS-1:0] pin_lvl;

    // Previous convert level, for edge finding
    logic conv_prev;

    // One-cycle convert sub-clock enable
    logic conv_tick;

    // Filtered control levels
    logic hiz_lvl;
    logic pd_lvl;

    // Phase machine
    padc_phase_t phase;
    padc_phase_t next_phase;
    // Counter runs down only in the timed phases
    logic [`PADC_CNT_W-1:0] ph_cnt;
    logic [`PADC_CNT_W-1:0] next_ph_cnt;

    // Aligned stage results
    padc_code_t aligned [0:`PADC_STAGES-1];

    // Corrected sum before clamp
    // One spare top bit flags overrange
    logic [`PADC_SUM_W-1:0] sum;

    // Word about to be presented
    padc_word_t next_word;

    // Valid qualifier travelling with samples
    logic [`PADC_LATENCY-1:0] vld_pipe;

    // ---------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------

    // Gather the pins so one loop filters them all
    assign pin_raw[`PADC_PIN_CONV] = CONV_CLK_IN;
    assign pin_raw[`PADC_PIN_HIZ] = OUTPUT_HIZ_IN;
    assign pin_raw[`PADC_PIN_PD] = POWER_DOWN_IN;

    // A pin may change at any instant, so each gets its own chain
    genvar gp;
    generate
        for (gp = 0; gp < `PADC_PINS; gp++) begin : g_sync
            // Three-flop chain per pin
            logic [2:0] sff;

            // Shift the pin in
            always_ff @(posedge CORE_CLK_IN) begin
                if (!RSTN_IN) begin
                    sff <= 3'h0;
                end else begin
                    sff <= {sff[1:0], pin_raw[gp]};
                end
            end

            // Level moves only when the last two agree,
            // which rejects a single metastable sample
            always_ff @(posedge CORE_CLK_IN) begin
                if (!RSTN_IN) begin
                    pin_lvl[gp] <= 1'h0;
                end else if (sff[1] == sff[2]) begin
                    pin_lvl[gp] <= sff[2];
                end
            end
        end
    endgenerate

    // Low default mirrors the pull-downs on both control pins
    assign hiz_lvl = pin_lvl[`PADC_PIN_HIZ]; // [R05]
    assign pd_lvl = pin_lvl[`PADC_PIN_PD];

    // ---------------------------------------------
    // Convert sub-clock
    // ---------------------------------------------

    // Remember last convert level
    // Filtered level keeps a glitch from making two ticks
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RSTN_IN) begin
            conv_prev <= 1'h0;
        end else begin
            conv_prev <= pin_lvl[`PADC_PIN_CONV];
        end
    end

    // Rising convert edge: every stage steps on this
    assign conv_tick = pin_lvl[`PADC_PIN_CONV] & ~conv_prev; // [R08]

    // ---------------------------------------------
    // Track/hold phase generator
    // ---------------------------------------------

    // Breaks keep the two phases from ever overlapping
    always_comb begin
        next_phase = phase;
        next_ph_cnt = ph_cnt;
        case (phase)
            PADC_IDLE: begin
                // Wait for first convert edge
                if (conv_tick) begin
                    next_phase = PADC_TRACK;
                    next_ph_cnt = `PADC_CNT_W'(`PADC_TRACK_CYC - 1);
                end
            end
            PADC_TRACK: begin
                // Input sampled onto capacitors
                if (ph_cnt == '0) begin
                    next_phase = PADC_BRK1;
                    next_ph_cnt = `PADC_CNT_W'(`PADC_BREAK_CYC - 1);
                end else begin
                    next_ph_cnt = ph_cnt - 1'h1;
                end
            end
            PADC_BRK1: begin
                // Both switches open
                if (ph_cnt == '0) begin
                    next_phase = PADC_HOLD;
                end else begin
                    next_ph_cnt = ph_cnt - 1'h1;
                end
            end
            PADC_HOLD: begin
                // Charge shares, held value forms
                if (conv_tick) begin
                    next_phase = PADC_BRK2;
                    next_ph_cnt = `PADC_CNT_W'(`PADC_BREAK_CYC - 1);
                end
            end
            PADC_BRK2: begin
                // Break before tracking again
                if (ph_cnt == '0) begin
                    next_phase = PADC_TRACK;
                    next_ph_cnt = `PADC_CNT_W'(`PADC_TRACK_CYC - 1);
                end else begin
                    next_ph_cnt = ph_cnt - 1'h1;
                end
            end
            default: begin
                next_phase = PADC_IDLE;
            end
        endcase
    end

    // Phase state; power-down parks the switches
    // Counter value is ignored while waiting for a tick
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RSTN_IN || pd_lvl) begin
            phase <= PADC_IDLE;
            ph_cnt <= '0;
        end else begin
            phase <= next_phase;
            ph_cnt <= next_ph_cnt;
        end
    end

    // Phase outputs from flops, so no decode glitch
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RSTN_IN || pd_lvl) begin
            TRACK_PHASE_OUT <= 1'h0;
            HOLD_PHASE_OUT <= 1'h0;
        end else begin
            TRACK_PHASE_OUT <= (next_phase == PADC_TRACK); // [R11]
            HOLD_PHASE_OUT <= (next_phase == PADC_HOLD); // [R11]
        end
    end

    // ---------------------------------------------
    // Stage delay lines
    // ---------------------------------------------

    // Stage k delivers its result k/2 ticks after
    // sampling, so its line is that much shorter
    // Stage 8 keeps a one-word line, stage 0 the full latency
    genvar gs;
    generate
        for (gs = 0; gs < `PADC_STAGES; gs++) begin : g_stage // [R07]
            localparam int DEPTH = `PADC_LATENCY - gs / 2;
            padc_code_t line [0:DEPTH-1];

            // Shift one place per convert tick
            always_ff @(posedge CORE_CLK_IN) begin
                if (!RSTN_IN) begin
                    for (int j = 0; j < DEPTH; j++) begin
                        line[j] <= 2'h0;
                    end
                end else if (conv_tick) begin // [R08]
                    line[0] <= STAGE_CODE_IN[gs*`PADC_CODE_W +: `PADC_CODE_W];
                    for (int j = 1; j < DEPTH; j++) begin
                        line[j] <= line[j-1]; // [R09]
                    end
                end
            end

            // Tap where all stages meet one sample
            assign aligned[gs] = line[DEPTH-1]; // [R09]
        end
    endgenerate

    // ---------------------------------------------
    // Error correction
    // ---------------------------------------------

    // Overlapping two-bit results add with one bit of
    // redundancy, so a slightly early comparator in one
    // stage is fixed by the next and no code goes missing
    always_comb begin
        sum = '0;
        for (int k = 0; k < `PADC_STAGES; k++) begin
            sum = sum + (`PADC_SUM_W'(aligned[k]) << (`PADC_STAGES - 1 - k)); // [R10]
        end
    end

    // Clamp overrange to full scale, never roll over
    // Overrange only comes from redundant codes near the top
    always_comb begin
        if (sum[`PADC_SUM_W-1]) begin
            next_word = `PADC_FULL_CODE; // [R02]
        end else begin
            next_word = sum[`PADC_WORD_W-1:0]; // [R02] [R03]
        end
    end

    // ---------------------------------------------
    // Output word and qualifier
    // ---------------------------------------------

    // One new word per tick, bit 0 least significant
    // Word holds between ticks so the capture side may sample late
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RSTN_IN) begin
            SAMPLE_OUT <= `PADC_ZERO_CODE;
        end else if (conv_tick) begin
            SAMPLE_OUT <= next_word; // [R01] [R14]
        end
    end

    // Validity rides with the sample; power-down flushes
    // it so the words of the refill come out flagged bad
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RSTN_IN || pd_lvl) begin
            vld_pipe <= '0; // [R13] [R15]
        end else if (conv_tick) begin
            vld_pipe <= {vld_pipe[`PADC_LATENCY-2:0], 1'h1}; // [R15]
        end
    end

    // Qualifier updates together with the word
    // Held low across power-down so no stale word looks good
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RSTN_IN || pd_lvl) begin
            SAMPLE_VALID_OUT <= 1'h0; // [R13]
        end else if (conv_tick) begin
            SAMPLE_VALID_OUT <= vld_pipe[`PADC_LATENCY-1]; // [R01] [R15]
        end
    end

    // ---------------------------------------------
    // Output drivers
    // ---------------------------------------------

    // Enable is low while driving; power-down wins over
    // the control pin. Filtering adds delay, so the pin
    // is only fit for static use
    // Reset drives the bus, as an open control pin would
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RSTN_IN) begin
            SAMPLE_OE_N_OUT <= 1'h0;
        end else if (pd_lvl) begin
            SAMPLE_OE_N_OUT <= 1'h1; // [R12]
        end else begin
            SAMPLE_OE_N_OUT <= hiz_lvl; // [R04] [R05] [R06]
        end
    end

endmodule : padc_top

// *** rtl/padc_params.svh ***
`ifndef PADC_PARAMS_SVH
`define PADC_PARAMS_SVH
// Function
// R01 - Word out five convert cycles after sampling
// R02 - Offset binary: ones top, zeros bottom
// R03 - Midscale gives only top bit set
// R04 - Output control high floats data lines
// R05 - Output control low or open drives data
// R06 - Output control used statically, not per sample
// R07 - Nine stages, two-bit quantizer each
// R08 - Stages step on convert-rate sub-clock
// R09 - Per-stage delay line aligns results
// R10 - Redundancy correction yields ten-bit word
// R11 - Non-overlapping two-phase track/hold clock
// R12 - Power-down floats data regardless of control
// R13 - Five words after power-down are invalid
// R14 - Bus bit 0 least, bit 9 most
// R15 - Valid qualifier rides the latency pipeline

// Structure
`define PADC_STAGES 9
`define PADC_CODE_W 2
`define PADC_WORD_W 10
`define PADC_SUM_W 11
`define PADC_LATENCY 5

// Codes
`define PADC_FULL_CODE 10'h3ff
`define PADC_MID_CODE 10'h200
`define PADC_ZERO_CODE 10'h000

// Pin synchroniser lanes
`define PADC_PINS 3
`define PADC_PIN_CONV 0
`define PADC_PIN_HIZ 1
`define PADC_PIN_PD 2

// Timing
`define PADC_CLK_MHZ 200
`define PADC_TRACK_NS 20
`define PADC_BREAK_NS 5
`define PADC_TRACK_CYC ((`PADC_TRACK_NS * `PADC_CLK_MHZ + 999) / 1000)
`define PADC_BREAK_CYC ((`PADC_BREAK_NS * `PADC_CLK_MHZ + 999) / 1000)
`define PADC_CNT_W 4

`endif

// *** rtl/padc_pkg.sv ***
package padc_pkg;

    // Track/hold phase states, one-hot
    typedef enum logic [4:0] {
        PADC_IDLE = 5'h01,
        PADC_TRACK = 5'h02,
        PADC_BRK1 = 5'h04,
        PADC_HOLD = 5'h08,
        PADC_BRK2 = 5'h10
    } padc_phase_t;

    // One stage result and one output word
    typedef logic [1:0] padc_code_t;
    typedef logic [9:0] padc_word_t;

endpackage : padc_pkg

// *** tb/padc_top_properties.sv ***
`timescale 1ns/1ps
module padc_checker (
    input wire logic CORE_CLK_IN,
    input wire logic RSTN_IN,
    input wire logic CONV_CLK_IN,
    input wire logic OUTPUT_HIZ_IN,
    input wire logic POWER_DOWN_IN,
    input wire logic [9:0] SAMPLE_OUT,
    input wire logic SAMPLE_OE_N_OUT,
    input wire logic SAMPLE_VALID_OUT,
    input wire logic TRACK_PHASE_OUT,
    input wire logic HOLD_PHASE_OUT
);
    // ------------------------------------------------------------
    // Output path and phase checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RSTN_IN);

    // Both switches closed at once would short the hold capacitors
    phase_overlap_a: assert property (!(TRACK_PHASE_OUT && HOLD_PHASE_OUT))
        else $error("track and hold phases overlap");
    // Power-down zeroes the phases, so it ends the sequence
    track_span_a: assert property (disable iff (!RSTN_IN || POWER_DOWN_IN)
        $rose(TRACK_PHASE_OUT) |-> TRACK_PHASE_OUT [*4] ##1
        !(TRACK_PHASE_OUT || HOLD_PHASE_OUT) ##1 HOLD_PHASE_OUT)
        else $error("track span or break wrong");
    // Seven cycles cover the pin filter plus the output flop
    hiz_float_a: assert property (OUTPUT_HIZ_IN [*7] |-> SAMPLE_OE_N_OUT)
        else $error("data not floated by output control");
    pd_float_a: assert property (POWER_DOWN_IN [*7] |-> SAMPLE_OE_N_OUT)
        else $error("data not floated in power-down");
    drive_ok_a: assert property (!(OUTPUT_HIZ_IN || POWER_DOWN_IN) [*7] |-> !SAMPLE_OE_N_OUT)
        else $error("data not driven");
    pd_invalid_a: assert property (POWER_DOWN_IN [*7] |-> !SAMPLE_VALID_OUT)
        else $error("valid high in power-down");
    // Ticks are at least four cycles apart, so eight cycles is well inside five words
    refill_wait_a: assert property ($fell(POWER_DOWN_IN) |-> !SAMPLE_VALID_OUT [*8])
        else $error("valid too early after power-down");
    // Words only move a few cycles after a convert edge
    word_step_a: assert property ($changed(SAMPLE_OUT) |->
        $past(CONV_CLK_IN, 3) || $past(CONV_CLK_IN, 4))
        else $error("word changed away from a convert edge");

    cover property ($rose(SAMPLE_VALID_OUT));
    cover property ($rose(SAMPLE_OE_N_OUT));
    cover property ($rose(HOLD_PHASE_OUT));
endmodule : padc_checker

bind padc_top padc_checker u_checker (.CORE_CLK_IN, .RSTN_IN, .CONV_CLK_IN, .OUTPUT_HIZ_IN,
    .POWER_DOWN_IN, .SAMPLE_OUT, .SAMPLE_OE_N_OUT, .SAMPLE_VALID_OUT, .TRACK_PHASE_OUT,
    .HOLD_PHASE_OUT);

// *** tb/padc_capture.sv ***
`timescale 1ns/1ps
module padc_capture (
    input wire logic clk_in,
    input wire logic [9:0] word_in,
    input wire logic oe_n_in,
    input wire logic valid_in,
    output logic [9:0] word_out
);
    // ------------------------------------------------------------
    // Downstream latch: takes only driven, qualified words
    // ------------------------------------------------------------
    // A floated bus carries nothing usable, so it is never taken
    always_ff @(posedge clk_in) begin
        if (valid_in && !oe_n_in) begin
            word_out <= word_in;
        end
    end
endmodule : padc_capture

// *** tb/tb.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
    import padc_pkg::*;
    // ------------------------------------------------------------
    // Stimulus state
    // ------------------------------------------------------------
    logic clk = 1'h0, rstn = 1'h0, conv = 1'h0, hiz = 1'h0, pd = 1'h0;
    logic [17:0] lanes = 18'h00000; // Stage results on the bus
    logic [17:0] smp [0:63]; // All nine stage codes of each sample
    logic [9:0] word, cap;
    logic oe_n, valid, trk, hld;
    int g = 0, loc = 0, fails = 0, compares = 0; // Global and since-release ticks

    padc_top DUT (.CORE_CLK_IN(clk), .RSTN_IN(rstn), .CONV_CLK_IN(conv),
        .STAGE_CODE_IN(lanes), .OUTPUT_HIZ_IN(hiz), .POWER_DOWN_IN(pd), .SAMPLE_OUT(word),
        .SAMPLE_OE_N_OUT(oe_n), .SAMPLE_VALID_OUT(valid), .TRACK_PHASE_OUT(trk),
        .HOLD_PHASE_OUT(hld));
    padc_capture u_cap (.clk_in(clk), .word_in(word), .oe_n_in(oe_n), .valid_in(valid),
        .word_out(cap));

    initial forever #2.5 clk = ~clk;

    // Weighted sum of stage codes, clamped at full scale
    function automatic padc_word_t word_of(logic [17:0] c);
        logic [10:0] s;
        s = 11'h000;
        for (int k = 0; k < 9; k++) s += 11'(c[2*k +: 2]) << (8 - k);
        return (s > 11'h3ff) ? 10'h3ff : s[9:0];
    endfunction : word_of

    // One convert period, four cycles high and four low; checks hold mid-period, the rest just before the next edge
    task automatic period();
        for (int k = 0; k < 9; k++) begin
            lanes[2*k +: 2] = (g >= k / 2) ? smp[g - k / 2][2*k +: 2] : 2'h0;
        end
        conv = 1'h1;
        repeat (4) @(negedge clk);
        `CHK(hld, 1'(loc > 0 && !pd));
        conv = 1'h0;
        repeat (4) @(negedge clk);
        `CHK(oe_n, pd | hiz);
        `CHK(trk, !pd);
        if (!pd) begin
            `CHK(valid, 1'(loc >= 5));
            if (loc >= 5) `CHK(word, word_of(smp[g - 5]));
        end
        g++;
        loc++;
    endtask : period

    task automatic print_verdict();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict

    // Run is about 1.3 microseconds; a hang is cut well after that
    initial begin
        #20000;
        fails++;
        print_verdict();
    end

    // ------------------------------------------------------------
    // Main sequence: full scale, midscale, zero, one below midscale, then random words
    // ------------------------------------------------------------
    initial begin
        void'($urandom(65));
        for (int i = 0; i < 64; i++) smp[i] = 18'($urandom());
        smp[0] = 18'h3ffff; // Sum overflows, clamps to all ones
        smp[1] = 18'h25555; // Midscale
        smp[2] = 18'h00000;
        smp[3] = 18'h15555;
        repeat (16) @(negedge clk);
        rstn = 1'h1;
        repeat (12) period();
        hiz = 1'h1; // Held for whole periods, never per sample
        repeat (3) period();
        hiz = 1'h0;
        pd = 1'h1;
        repeat (4) @(negedge clk);
        repeat (3) period();
        pd = 1'h0;
        repeat (4) @(negedge clk);
        `CHK(cap, word_of(smp[6]));
        loc = 0;
        repeat (12) period();
        `CHK(cap, word_of(smp[g - 6]));
        print_verdict();
    end
endmodule : tb
